// [design/adcsr_defines.svh]
`ifndef ADCSR_DEFINES_SVH
`define ADCSR_DEFINES_SVH

// status word field positions
`define ADCSR_ST_ZERO       15
`define ADCSR_ST_BUSY       14
`define ADCSR_ST_CHAN_HI    13
`define ADCSR_ST_CHAN_LO    10
`define ADCSR_ST_PWR_HI     9
`define ADCSR_ST_PWR_LO     8
`define ADCSR_ST_RDSEL_HI   7
`define ADCSR_ST_RDSEL_LO   6
`define ADCSR_ST_IFMODE     5
`define ADCSR_ST_DONTCARE   4
`define ADCSR_ST_CALTYPE    3
`define ADCSR_ST_GRP_HI     2
`define ADCSR_ST_GRP_LO     1
`define ADCSR_ST_CALRUN     0
`define ADCSR_STATUS_RESET  16'h0000

// control word field positions, same layout as the status word
`define ADCSR_CT_CHAN_HI    13
`define ADCSR_CT_CHAN_LO    10
`define ADCSR_CT_PWR_HI     9
`define ADCSR_CT_PWR_LO     8
`define ADCSR_CT_RDSEL_HI   7
`define ADCSR_CT_RDSEL_LO   6
`define ADCSR_CT_IFMODE     5
`define ADCSR_CT_CALTYPE    3
`define ADCSR_CT_GRP_HI     2
`define ADCSR_CT_GRP_LO     1
`define ADCSR_CT_CALSTART   0

// read-select codes
`define ADCSR_RDSEL_CAL     2'h2
`define ADCSR_RDSEL_STATUS  2'h3

// calibration register indices, reset value, data mask and frame bit count
`define ADCSR_IDX_GAIN      4'h0
`define ADCSR_IDX_OFFSET    4'h1
`define ADCSR_IDX_DAC0      4'h2
`define ADCSR_IDX_LAST      4'h9
`define ADCSR_CAL_RESET     16'h0000
`define ADCSR_CAL_DATA_MASK 16'h3FFF
`define ADCSR_FRAME_BITS    5'h10

`endif

// [design/adcsr_pkg.sv]
package adcsr_pkg;
	typedef enum logic [1:0]
	{
		ADCSR_GRP_ALL,
		ADCSR_GRP_GAIN_OFFSET,
		ADCSR_GRP_OFFSET,
		ADCSR_GRP_GAIN
	} adcsr_group_e;

	typedef logic [3:0]  adcsr_idx_t;
	typedef logic [15:0] adcsr_word_t;
endpackage

// [design/adcsr_shifter.sv]
`timescale 1ns/1ps
`include "adcsr_defines.svh"

// 16-bit msb-first frame shifter toward the serial data output
module adcsr_shifter
	import adcsr_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        load,
	input  wire adcsr_word_t load_word,
	input  wire logic        shift_en,
	output logic             sdata,
	output logic             frame_busy
);
	adcsr_word_t shreg;
	adcsr_word_t next_shreg;
	logic [4:0]  left;
	logic [4:0]  next_left;

	// a new load replaces any frame still running
	always_comb
	begin
		next_shreg = shreg;
		next_left  = left;
		if (load)
		begin
			next_shreg = load_word;
			next_left  = `ADCSR_FRAME_BITS;
		end
		else if (shift_en && left != 5'h00)
		begin
			next_shreg = {shreg[14:0], 1'b0};
			next_left  = left - 5'h01;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			shreg <= 16'h0000;
			left  <= 5'h00;
		end
		else
		begin
			shreg <= next_shreg;
			left  <= next_left;
		end
	end

	assign sdata      = (left != 5'h00) ? shreg[15] : 1'b0;
	assign frame_busy = (left != 5'h00);
endmodule

// [design/adcsr_regs.sv]
`timescale 1ns/1ps
`include "adcsr_defines.svh"

module adcsr_regs
	import adcsr_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        ctrl_wr,
	input  wire adcsr_word_t ctrl_wdata,
	input  wire logic        cal_wr,
	input  wire adcsr_word_t cal_wdata,
	input  wire logic        rd_start,
	input  wire logic        read_done,
	input  wire logic        shift_en,
	input  wire logic        conv_busy,
	input  wire logic        cal_running,
	input  wire logic        eng_wr,
	input  wire adcsr_idx_t  eng_idx,
	input  wire adcsr_word_t eng_wdata,
	output logic             sdata,
	output logic             frame_busy,
	output adcsr_word_t      device_status_word,
	output adcsr_word_t      rd_word,
	output adcsr_idx_t       cal_ptr,
	output logic             cal_cmd,
	output logic             input_mode_sel,
	output logic [2:0]       chan_sel,
	output logic [1:0]       power_cfg,
	output logic             cal_type_sel,
	output logic             iface_two_wire,
	output logic [1:0]       read_select,
	output logic [1:0]       cal_group_sel
);
	////////////////////////////////////////////////////////////////////////////
	// helpers

	// first register of a group
	function automatic adcsr_idx_t first_idx(input logic [1:0] grp);
		first_idx = (adcsr_group_e'(grp) == ADCSR_GRP_OFFSET) ? `ADCSR_IDX_OFFSET
			: `ADCSR_IDX_GAIN;
	endfunction

	// last register of a group
	function automatic adcsr_idx_t last_idx(input logic [1:0] grp);
		case (adcsr_group_e'(grp))
			ADCSR_GRP_ALL:         last_idx = `ADCSR_IDX_LAST;
			ADCSR_GRP_GAIN_OFFSET: last_idx = `ADCSR_IDX_OFFSET;
			ADCSR_GRP_OFFSET:      last_idx = `ADCSR_IDX_OFFSET;
			ADCSR_GRP_GAIN:        last_idx = `ADCSR_IDX_GAIN;
			default:               last_idx = `ADCSR_IDX_GAIN;
		endcase
	endfunction

	// calibration frames come only from read-select 10
	function automatic logic sel_is_cal(input logic [1:0] rs);
		sel_is_cal = (rs == `ADCSR_RDSEL_CAL);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// control settings, mirrored into status except read_select and cal_cmd

	logic       next_input_mode_sel;
	logic [2:0] next_chan_sel;
	logic [1:0] next_power_cfg;
	logic       next_cal_type_sel;
	logic       next_iface_two_wire;
	logic [1:0] next_read_select;
	logic [1:0] next_cal_group_sel;
	logic       next_cal_cmd;

	// a control write loads all settings; interface mode drops after reads
	always_comb
	begin
		next_input_mode_sel = input_mode_sel;
		next_chan_sel       = chan_sel;
		next_power_cfg      = power_cfg;
		next_cal_type_sel   = cal_type_sel;
		next_iface_two_wire = iface_two_wire;
		next_read_select    = read_select;
		next_cal_group_sel  = cal_group_sel;
		next_cal_cmd        = cal_cmd; // held until the next control write
		if (read_done)
			next_iface_two_wire = 1'b0;
		if (ctrl_wr)
		begin
			next_input_mode_sel = ctrl_wdata[`ADCSR_CT_CHAN_HI];
			next_chan_sel       = ctrl_wdata[`ADCSR_CT_CHAN_HI-1:`ADCSR_CT_CHAN_LO];
			next_power_cfg      = ctrl_wdata[`ADCSR_CT_PWR_HI:`ADCSR_CT_PWR_LO];
			next_cal_type_sel   = ctrl_wdata[`ADCSR_CT_CALTYPE];
			// write wins over the clear so a two-wire host can keep it set
			next_iface_two_wire = ctrl_wdata[`ADCSR_CT_IFMODE];
			next_read_select    = ctrl_wdata[`ADCSR_CT_RDSEL_HI:`ADCSR_CT_RDSEL_LO];
			next_cal_group_sel  = ctrl_wdata[`ADCSR_CT_GRP_HI:`ADCSR_CT_GRP_LO];
			next_cal_cmd        = ctrl_wdata[`ADCSR_CT_CALSTART];
		end
	end

	// settings registers
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			input_mode_sel <= 1'b0;
			chan_sel       <= 3'h0;
			power_cfg      <= 2'h0;
			cal_type_sel   <= 1'b0;
			iface_two_wire <= 1'b0;
			read_select    <= 2'h0;
			cal_group_sel  <= 2'h0;
			cal_cmd        <= 1'b0;
		end
		else
		begin
			input_mode_sel <= next_input_mode_sel;
			chan_sel       <= next_chan_sel;
			power_cfg      <= next_power_cfg;
			cal_type_sel   <= next_cal_type_sel;
			iface_two_wire <= next_iface_two_wire;
			read_select    <= next_read_select;
			cal_group_sel  <= next_cal_group_sel;
			cal_cmd        <= next_cal_cmd;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status word, built from live state; no write path exists

	logic busy_q;
	logic calrun_q;

	// busy flags registered so the status word stays a flop output
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			busy_q   <= 1'b0;
			calrun_q <= 1'b0;
		end
		else
		begin
			busy_q   <= conv_busy | cal_running;
			calrun_q <= cal_running;
		end
	end

	// status view: constants, mirrored settings and registered busy flags
	always_comb
	begin
		device_status_word = `ADCSR_STATUS_RESET;
		device_status_word[`ADCSR_ST_ZERO]     = 1'b0;
		device_status_word[`ADCSR_ST_BUSY]     = busy_q;
		device_status_word[`ADCSR_ST_CHAN_HI]  = input_mode_sel;
		device_status_word[`ADCSR_ST_CHAN_HI-1:`ADCSR_ST_CHAN_LO] = chan_sel;
		device_status_word[`ADCSR_ST_PWR_HI:`ADCSR_ST_PWR_LO] = power_cfg;
		device_status_word[`ADCSR_ST_RDSEL_HI] = 1'b1;
		device_status_word[`ADCSR_ST_RDSEL_LO] = 1'b1;
		device_status_word[`ADCSR_ST_IFMODE]   = iface_two_wire;
		device_status_word[`ADCSR_ST_DONTCARE] = 1'b0;
		device_status_word[`ADCSR_ST_CALTYPE]  = cal_type_sel;
		device_status_word[`ADCSR_ST_GRP_HI:`ADCSR_ST_GRP_LO] = cal_group_sel;
		device_status_word[`ADCSR_ST_CALRUN]   = calrun_q;
	end

	////////////////////////////////////////////////////////////////////////////
	// calibration register file and pointer

	adcsr_word_t cal_mem [0:9];
	adcsr_word_t next_cal_mem [0:9];
	adcsr_idx_t  next_cal_ptr;
	logic        cal_rd;
	logic        host_access;
	logic        host_step;
	logic        host_wr_ok;
	logic        ptr_at_end;
	adcsr_idx_t  grp_head;
	adcsr_idx_t  wr_head;

	// host accesses; a pending calibration command blocks host writes and pointer steps, reads still shift out
	assign cal_rd      = rd_start && sel_is_cal(read_select);
	assign host_access = cal_wr || cal_rd;
	assign host_step   = host_access && !cal_cmd;
	assign host_wr_ok  = cal_wr && !cal_cmd;

	// group ends and heads, decoded once for the pointer update
	assign ptr_at_end = (cal_ptr == last_idx(cal_group_sel));
	assign grp_head   = first_idx(cal_group_sel);
	assign wr_head    = first_idx(ctrl_wdata[`ADCSR_CT_GRP_HI:`ADCSR_CT_GRP_LO]);

	// pointer steps through the group, wraps to its head when done
	always_comb
	begin
		next_cal_ptr = cal_ptr;
		if (ctrl_wr)
			next_cal_ptr = wr_head;
		else if (host_step)
		begin
			if (ptr_at_end)
				next_cal_ptr = grp_head;
			else
				next_cal_ptr = cal_ptr + 4'h1;
		end
	end

	// engine writes take priority; the host is idle during calibration
	genvar gi;
	generate
		for (gi = 0; gi < 10; gi++)
		begin : g_cal
			always_comb
			begin
				next_cal_mem[gi] = cal_mem[gi];
				if (eng_wr && eng_idx == 4'(gi))
					next_cal_mem[gi] = eng_wdata & `ADCSR_CAL_DATA_MASK;
				else if (host_wr_ok && cal_ptr == 4'(gi))
					next_cal_mem[gi] = cal_wdata & `ADCSR_CAL_DATA_MASK;
			end

			always_ff @(posedge sys_clk)
			begin
				if (!rst_b)
					cal_mem[gi] <= `ADCSR_CAL_RESET;
				else
					cal_mem[gi] <= next_cal_mem[gi];
			end
		end
	endgenerate

	// pointer register; power-up points at gain
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			cal_ptr <= `ADCSR_IDX_GAIN;
		else
			cal_ptr <= next_cal_ptr;
	end

	////////////////////////////////////////////////////////////////////////////
	// read word selection and serial output

	adcsr_word_t next_rd_word;
	adcsr_word_t sel_word;
	adcsr_word_t cal_word;

	// word under the pointer; an index past the last register reads zero
	assign cal_word = (cal_ptr <= `ADCSR_IDX_LAST)
		? (cal_mem[cal_ptr] & `ADCSR_CAL_DATA_MASK) : 16'h0000;

	// status for 11, calibration for 10; other codes read zero here
	always_comb
	begin
		case (read_select)
			`ADCSR_RDSEL_STATUS: sel_word = device_status_word;
			`ADCSR_RDSEL_CAL:    sel_word = cal_word;
			default:             sel_word = 16'h0000;
		endcase
		next_rd_word = rd_start ? sel_word : rd_word;
	end

	// last latched frame word
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			rd_word <= 16'h0000;
		else
			rd_word <= next_rd_word;
	end

	adcsr_shifter u_shifter
	(
		.sys_clk    (sys_clk),
		.rst_b      (rst_b),
		.load       (rd_start),
		.load_word  (sel_word),
		.shift_en   (shift_en),
		.sdata      (sdata),
		.frame_busy (frame_busy)
	);
endmodule

// [tb/adcsr_checker.sv]
`timescale 1ns/1ps
// port-level watch on the register block
module adcsr_checker
	import adcsr_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst_b,
	input wire logic        ctrl_wr,
	input wire adcsr_word_t ctrl_wdata,
	input wire logic        cal_wr,
	input wire logic        rd_start,
	input wire logic        read_done,
	input wire logic        conv_busy,
	input wire logic        cal_running,
	input wire logic        sdata,
	input wire adcsr_word_t device_status_word,
	input wire adcsr_word_t rd_word,
	input wire adcsr_idx_t  cal_ptr,
	input wire logic        cal_cmd,
	input wire logic        input_mode_sel,
	input wire logic [2:0]  chan_sel,
	input wire logic [1:0]  power_cfg,
	input wire logic        cal_type_sel,
	input wire logic        iface_two_wire,
	input wire logic [1:0]  read_select,
	input wire logic [1:0]  cal_group_sel
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// frame requests; a same-cycle control write would move the target
	sequence seq_cal_rd;
		rd_start && read_select == 2'h2 && !ctrl_wr;
	endsequence
	sequence seq_full_rd;
		rd_start && read_select == 2'h2 && cal_group_sel == 2'h0 && !ctrl_wr && !cal_cmd;
	endsequence
	sequence seq_st_rd;
		rd_start && read_select == 2'h3 && !ctrl_wr;
	endsequence
	////////////////////////////////////////
	zero_bit_a: assert property (device_status_word[15] == 1'b0)
		else $error("status bit 15 set");
	src_bits_a: assert property (device_status_word[7:6] == 2'h3)
		else $error("status source bits wrong");
	busy_bit_a: assert property (1'b1 |=> device_status_word[14] == $past(conv_busy || cal_running))
		else $error("busy bit wrong");
	cal_run_a: assert property (1'b1 |=> device_status_word[0] == $past(cal_running))
		else $error("calibrating bit wrong");
	ctrl_mirror_a: assert property (ctrl_wr |=>
		device_status_word[13:8] == $past(ctrl_wdata[13:8]) && device_status_word[3:1] ==
		$past(ctrl_wdata[3:1]) && iface_two_wire == $past(ctrl_wdata[5]))
		else $error("status does not mirror control");
	mode_clear_a: assert property (read_done && !ctrl_wr |=> !iface_two_wire)
		else $error("interface mode not cleared");
	status_ro_a: assert property (!ctrl_wr && !read_done |=> $stable(device_status_word[13:1]))
		else $error("status changed without control write");
	ptr_reset_a: assert property (ctrl_wr |=>
		cal_ptr == (($past(ctrl_wdata[2:1]) == 2'h2) ? 4'h1 : 4'h0))
		else $error("pointer not reset");
	ptr_step_a: assert property (seq_full_rd |=>
		cal_ptr == (($past(cal_ptr) == 4'h9) ? 4'h0 : $past(cal_ptr) + 4'h1))
		else $error("pointer did not step");
	lead_zero_a: assert property (seq_cal_rd |=> rd_word[15:14] == 2'h0)
		else $error("leading bits not zero");
	status_frame_a: assert property (seq_st_rd |=> rd_word == $past(device_status_word))
		else $error("status frame wrong");
	frame_msb_a: assert property (rd_start |=> sdata == rd_word[15])
		else $error("first frame bit wrong");
	ctrl_regs_a: assert property (ctrl_wr |=>
		{input_mode_sel, chan_sel, power_cfg, cal_type_sel, cal_cmd} ==
		$past({ctrl_wdata[13:8], ctrl_wdata[3], ctrl_wdata[0]}))
		else $error("control registers do not follow write");
	cmd_hold_a: assert property ((cal_wr || rd_start) && cal_cmd && !ctrl_wr |=>
		cal_ptr == $past(cal_ptr))
		else $error("pointer moved during calibration command");
endmodule

bind adcsr_regs adcsr_checker i_chk (.sys_clk, .rst_b, .ctrl_wr, .ctrl_wdata, .cal_wr,
	.rd_start, .read_done, .conv_busy, .cal_running, .sdata, .device_status_word, .rd_word,
	.cal_ptr, .cal_cmd, .input_mode_sel, .chan_sel, .power_cfg, .cal_type_sel,
	.iface_two_wire, .read_select, .cal_group_sel);

// [tb/adcsr_host.sv]
`timescale 1ns/1ps
// host model: strobes change on falling edges only
module adcsr_host
	import adcsr_pkg::*;
(
	input  wire logic  sys_clk,
	input  wire logic  sdata,
	output logic       ctrl_wr,
	output adcsr_word_t ctrl_wdata,
	output logic       cal_wr,
	output adcsr_word_t cal_wdata,
	output logic       rd_start,
	output logic       read_done,
	output logic       shift_en
);
	initial
	begin
		{ctrl_wr, cal_wr, rd_start, read_done, shift_en} = 5'h00;
		ctrl_wdata = 16'h0000;
		cal_wdata = 16'h0000;
	end
	// data bus shows junk once released, never the old word
	task automatic ctrl(input adcsr_word_t w);
		@(negedge sys_clk);
		ctrl_wdata = w;
		ctrl_wr = 1'b1;
		@(negedge sys_clk);
		ctrl_wr = 1'b0;
		ctrl_wdata = ~w;
	endtask
	// writes only, never mixed with reads in one sequence
	task automatic calw(input adcsr_word_t w);
		@(negedge sys_clk);
		cal_wdata = w;
		cal_wr = 1'b1;
		@(negedge sys_clk);
		cal_wr = 1'b0;
		cal_wdata = ~w;
	endtask
	// whole frame always, so two-wire reads are never cut short
	task automatic rd(output adcsr_word_t w);
		@(negedge sys_clk);
		rd_start = 1'b1;
		@(negedge sys_clk);
		rd_start = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			w[i] = sdata;
			shift_en = 1'b1;
			@(negedge sys_clk);
		end
		shift_en = 1'b0;
		read_done = 1'b1;
		@(negedge sys_clk);
		read_done = 1'b0;
	endtask
endmodule

// [tb/test_adc_status_and_cal_register_access.sv]
`timescale 1ns/1ps
// self-checking bench for the status and calibration register block
module test_adc_status_and_cal_register_access
	import adcsr_pkg::*;
;
	logic        sys_clk, rst_b, conv_busy, cal_running, eng_wr;
	adcsr_idx_t  eng_idx, cal_ptr;
	wire logic   ctrl_wr, cal_wr, rd_start, read_done, shift_en, sdata, frame_busy;
	adcsr_word_t ctrl_wdata, cal_wdata, device_status_word, eng_wdata, w;
	adcsr_word_t exp[10];
	int          error_cnt, cmp_count;

	adcsr_regs i_adcsr_regs (.sys_clk, .rst_b, .ctrl_wr, .ctrl_wdata, .cal_wr, .cal_wdata,
		.rd_start, .read_done, .shift_en, .conv_busy, .cal_running, .eng_wr, .eng_idx,
		.eng_wdata, .sdata, .frame_busy, .device_status_word, .rd_word(), .cal_ptr,
		.cal_cmd(), .input_mode_sel(), .chan_sel(), .power_cfg(), .cal_type_sel(),
		.iface_two_wire(), .read_select(), .cal_group_sel());
	adcsr_host i_host (.sys_clk, .sdata, .ctrl_wr, .ctrl_wdata, .cal_wr, .cal_wdata,
		.rd_start, .read_done, .shift_en);
	////////////////////////////////////////
	task automatic chk(input string n, input adcsr_word_t e, input adcsr_word_t g);
		cmp_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic finish_test;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// mirrors, busy bits, mode clear after a read
	task automatic t_status;
		chk("st_reset", 16'h00C0, device_status_word);
		i_host.ctrl(16'h36EC);
		i_host.rd(w);
		chk("st_frame", 16'h36EC, w);
		chk("fr_end", 16'h0000, {15'h0000, frame_busy});
		chk("st_mode", 16'h36CC, device_status_word);
		i_host.calw(16'hFFFF);
		chk("st_ro", 16'h36CC, device_status_word);
		conv_busy = 1'b1;
		@(negedge sys_clk);
		chk("st_busy", 16'h76CC, device_status_word);
		conv_busy = 1'b0;
		cal_running = 1'b1;
		@(negedge sys_clk);
		chk("st_cal", 16'h76CD, device_status_word);
		cal_running = 1'b0;
		@(negedge sys_clk);
		chk("st_idle", 16'h36CC, device_status_word);
	endtask
	// all ten written, one overwritten by the engine, read back in order
	task automatic t_cal;
		i_host.ctrl(16'h0000);
		for (int i = 0; i < 10; i++)
		begin
			exp[i] = 16'(16'h0505 * (i + 1));
			i_host.calw(exp[i] | 16'hC000);
		end
		exp[3] = 16'h1234;
		eng_idx = 4'h3;
		eng_wdata = exp[3] | 16'hC000;
		eng_wr = 1'b1;
		@(negedge sys_clk);
		eng_wr = 1'b0;
		i_host.ctrl(16'h0080);
		for (int i = 0; i < 10; i++)
		begin
			i_host.rd(w);
			chk("cal_rd", exp[i], w);
			chk("cal_ptr", 16'((i + 1) % 10), {12'h000, cal_ptr});
		end
	endtask
	// short groups: start point and stepping
	task automatic t_groups;
		for (int g = 1; g < 4; g++)
		begin
			i_host.ctrl(16'h0080 | 16'(g << 1));
			chk("grp_ptr", (g == 2) ? 16'h0001 : 16'h0000, {12'h000, cal_ptr});
			i_host.rd(w);
			chk("grp_rd", (g == 2) ? exp[1] : exp[0], w);
			chk("grp_next", (g == 3) ? 16'h0000 : 16'h0001, {12'h000, cal_ptr});
		end
	endtask
	// abandoned sequence restarts on the next control write
	task automatic t_abort;
		i_host.ctrl(16'h0080);
		repeat (3) i_host.rd(w);
		chk("ab_ptr", 16'h0003, {12'h000, cal_ptr});
		i_host.ctrl(16'h0080);
		i_host.rd(w);
		chk("ab_rd", exp[0], w);
		i_host.ctrl(16'h0001);
		i_host.calw(16'h2AAA);
		chk("cmd_ptr", 16'h0000, {12'h000, cal_ptr});
		i_host.ctrl(16'h0080);
		i_host.rd(w);
		chk("cmd_rd", exp[0], w);
	endtask
	////////////////////////////////////////
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// generous limit: the sequence needs well under 1000 cycles
	initial
	begin
		#(25 * 5000);
		error_cnt++;
		finish_test();
	end
	initial
	begin
		{rst_b, conv_busy, cal_running, eng_wr} = 4'h0;
		eng_idx = 4'h0;
		eng_wdata = 16'h0000;
		repeat (4) @(negedge sys_clk);
		rst_b = 1'b1;
		@(negedge sys_clk);
		t_status();
		t_cal();
		t_groups();
		t_abort();
		finish_test();
	end
endmodule
